// ---- hdl/ssr_defines.vh ----
// Constants for the sync source select register bank: offsets, fields,
// reset values. Included by bare name from every design file.
`ifndef SSR_DEFINES_VH
`define SSR_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SSR_ADDR_W 8
`define SSR_DATA_W 16
`define SSR_OFS_RSVD_A 8'h1C
`define SSR_OFS_RSVD_B 8'h1D
`define SSR_OFS_CORR_SEL 8'h1E
`define SSR_OFS_MIXOSC_SEL 8'h1F
// Shadow (write) and active (read-back) windows, one word per group
`define SSR_OFS_SHADOW_BASE 8'h10
`define SSR_OFS_ACTIVE_BASE 8'h14
`define SSR_NUM_GROUPS 4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SSR_RST_RSVD_A 16'h0000
`define SSR_RST_RSVD_B 16'h0000
`define SSR_RST_CORR_SEL 16'h1111
`define SSR_RST_MIXOSC_SEL 16'h1140
`define SSR_RST_SHADOW 16'h0000

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SSR_HI_SEL_MSB 15
`define SSR_HI_SEL_LSB 12
`define SSR_LO_SEL_MSB 7
`define SSR_LO_SEL_LSB 4
`define SSR_FMT_SEL_MSB 3
`define SSR_FMT_SEL_LSB 2
`define SSR_SW_SYNC_BIT 1
// Bit order inside every four-bit select field
`define SSR_SRC_SW 3
`define SSR_SRC_PIN 2
`define SSR_SRC_STROBE 1
`define SSR_SRC_LOCAL 0
// Formatter source codes
`define SSR_FMT_FRAME 2'h0
`define SSR_FMT_PIN 2'h1

// Group indices
`define SSR_GRP_OFFSET 0
`define SSR_GRP_CORR 1
`define SSR_GRP_MIXER 2
`define SSR_GRP_OSC 3

`endif

// ---- hdl/ssr_shadow_reg.v ----
// Double-buffered register: shadow written by software, active copy
// updated on a sync. Assumes one clock and a synchronous reset.
`timescale 1ns/1ps
`include "ssr_defines.vh"

module ssr_shadow_reg #(
   parameter DATA_W = 16
) (
   // Clock and reset
   input wire sys_clk_i,
   input wire sys_rst_i,
   // Software side
   input wire wr_i,
   input wire [DATA_W-1:0] wdata_i,
   // Sync event for this group
   input wire sync_i,
   // Stored values
   output reg [DATA_W-1:0] shadow_o,
   output reg [DATA_W-1:0] active_o
);

   // ------------------------------------------------------------------
   // Shadow and active storage
   // ------------------------------------------------------------------
   // A sync in the same cycle as a write takes the new value, so an
   // auto-sync write lands at once rather than one sync late
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         shadow_o <= `SSR_RST_SHADOW;
         active_o <= `SSR_RST_SHADOW;
      end else begin
         if (wr_i) begin
            shadow_o <= wdata_i;
         end
         if (sync_i) begin
            active_o <= wr_i ? wdata_i : shadow_o;
         end
      end
   end

endmodule

// ---- hdl/ssr_sync_regs.v ----
// Sync source select register bank with four double-buffered groups:
// offset, gain/phase correction, mixer and oscillator phase.
// Assumes all pins are synchronous to sys_clk_i and that software uses
// the plain register port with read data one cycle after the strobe.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "ssr_defines.vh"

// Functional notes
// - Offset group sync enables at correction register bits 15:12, reset 0001.
// - Gain/phase group sync enables at bits 7:4, reset 0001.
// - Mixer group sync enables at mixer register bits 15:12, reset 0001.
// - Oscillator sync enables at bits 7:4, frame as bit 4, reset 0100.
// - Each set select bit enables a source; any enabled source syncs.
// - Formatter takes one source: 00 frame, 01 pin, others none.
// - With auto-sync enabled a write to the offset, gain/phase or mixer group is itself a sync.
module ssr_sync_regs #(
   parameter ADDR_W = `SSR_ADDR_W,
   parameter DATA_W = `SSR_DATA_W
) (
   // Clock and reset
   input wire sys_clk_i,
   input wire sys_rst_i,
   // Register port
   input wire [ADDR_W-1:0] reg_addr_i,
   input wire [DATA_W-1:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [DATA_W-1:0] reg_rdata_o,
   // Sync sources
   input wire sync_pin_i,
   input wire output_strobe_pin_i,
   input wire frame_strobe_i,
   // Active values of the double-buffered groups
   output wire [DATA_W-1:0] offset_active_o,
   output wire [DATA_W-1:0] corr_active_o,
   output wire [DATA_W-1:0] mixer_active_o,
   output wire [DATA_W-1:0] osc_phase_active_o,
   // Sync pulses, one cycle after the sync that caused them
   output reg [`SSR_NUM_GROUPS-1:0] group_sync_o,
   output reg formatter_sync_o
);

   // ------------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------------
   reg [DATA_W-1:0] rsvd_a;
   reg [DATA_W-1:0] rsvd_b;
   reg [DATA_W-1:0] corr_sel;
   reg [DATA_W-1:0] mixosc_sel;

   wire wr_rsvd_a;
   wire wr_rsvd_b;
   wire wr_corr_sel;
   wire wr_mixosc_sel;

   assign wr_rsvd_a = reg_wr_i && (reg_addr_i == `SSR_OFS_RSVD_A);
   assign wr_rsvd_b = reg_wr_i && (reg_addr_i == `SSR_OFS_RSVD_B);
   assign wr_corr_sel = reg_wr_i && (reg_addr_i == `SSR_OFS_CORR_SEL);
   assign wr_mixosc_sel = reg_wr_i && (reg_addr_i == `SSR_OFS_MIXOSC_SEL);

   // Reserved words are stored as written; their contents steer nothing
   // here, so a host that breaks the default only changes read-back
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         rsvd_a <= `SSR_RST_RSVD_A;
         rsvd_b <= `SSR_RST_RSVD_B;
         corr_sel <= `SSR_RST_CORR_SEL;
         mixosc_sel <= `SSR_RST_MIXOSC_SEL;
      end else begin
         if (wr_rsvd_a) begin
            rsvd_a <= reg_wdata_i;
         end
         if (wr_rsvd_b) begin
            rsvd_b <= reg_wdata_i;
         end
         if (wr_corr_sel) begin
            corr_sel <= reg_wdata_i;
         end
         if (wr_mixosc_sel) begin
            mixosc_sel <= reg_wdata_i;
         end
      end
   end

   // ------------------------------------------------------------------
   // Select fields
   // ------------------------------------------------------------------
   wire [3:0] sel_offset;
   wire [3:0] sel_corr;
   wire [3:0] sel_mixer;
   wire [3:0] sel_osc;
   wire [1:0] sel_fmt;
   wire sw_sync;

   assign sel_offset = corr_sel[`SSR_HI_SEL_MSB:`SSR_HI_SEL_LSB];
   assign sel_corr = corr_sel[`SSR_LO_SEL_MSB:`SSR_LO_SEL_LSB];
   assign sel_mixer = mixosc_sel[`SSR_HI_SEL_MSB:`SSR_HI_SEL_LSB];
   assign sel_osc = mixosc_sel[`SSR_LO_SEL_MSB:`SSR_LO_SEL_LSB];
   assign sel_fmt = mixosc_sel[`SSR_FMT_SEL_MSB:`SSR_FMT_SEL_LSB];
   // Level source: stays asserted as long as software leaves it at one
   assign sw_sync = mixosc_sel[`SSR_SW_SYNC_BIT];

   // ------------------------------------------------------------------
   // Shadow write decode
   // ------------------------------------------------------------------
   wire [`SSR_NUM_GROUPS-1:0] grp_wr;
   wire [DATA_W-1:0] grp_shadow [0:`SSR_NUM_GROUPS-1];
   wire [DATA_W-1:0] grp_active [0:`SSR_NUM_GROUPS-1];
   wire [3:0] grp_sel [0:`SSR_NUM_GROUPS-1];
   wire [3:0] grp_src [0:`SSR_NUM_GROUPS-1];
   wire [`SSR_NUM_GROUPS-1:0] grp_sync;

   assign grp_sel[`SSR_GRP_OFFSET] = sel_offset;
   assign grp_sel[`SSR_GRP_CORR] = sel_corr;
   assign grp_sel[`SSR_GRP_MIXER] = sel_mixer;
   assign grp_sel[`SSR_GRP_OSC] = sel_osc;

   genvar g;
   generate
      for (g = 0; g < `SSR_NUM_GROUPS; g = g + 1) begin : gen_grp
         wire local_src;

         assign grp_wr[g] = reg_wr_i &&
            (reg_addr_i == `SSR_OFS_SHADOW_BASE + g);
         // Oscillator group uses the frame strobe in place of auto-sync
         if (g == `SSR_GRP_OSC) begin : gen_frame
            assign local_src = frame_strobe_i;
         end else begin : gen_auto
            assign local_src = grp_wr[g];
         end
         assign grp_src[g] = {sw_sync, sync_pin_i, output_strobe_pin_i,
            local_src};
         // Any enabled source fires the group
         assign grp_sync[g] = |(grp_src[g] & grp_sel[g]);

         ssr_shadow_reg #(
            .DATA_W(DATA_W)
         ) u_shadow (
            .sys_clk_i(sys_clk_i),
            .sys_rst_i(sys_rst_i),
            .wr_i(grp_wr[g]),
            .wdata_i(reg_wdata_i),
            .sync_i(grp_sync[g]),
            .shadow_o(grp_shadow[g]),
            .active_o(grp_active[g])
         );
      end
   endgenerate

   assign offset_active_o = grp_active[`SSR_GRP_OFFSET];
   assign corr_active_o = grp_active[`SSR_GRP_CORR];
   assign mixer_active_o = grp_active[`SSR_GRP_MIXER];
   assign osc_phase_active_o = grp_active[`SSR_GRP_OSC];

   // ------------------------------------------------------------------
   // Formatter sync, single source
   // ------------------------------------------------------------------
   reg next_fmt_sync;

   always @* begin
      next_fmt_sync = 1'b0;
      case (sel_fmt)
         `SSR_FMT_FRAME: begin
            next_fmt_sync = frame_strobe_i;
         end
         `SSR_FMT_PIN: begin
            next_fmt_sync = sync_pin_i;
         end
         default: begin
            next_fmt_sync = 1'b0;
         end
      endcase
   end

   // Registered so downstream logic sees glitch-free pulses
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         group_sync_o <= {`SSR_NUM_GROUPS{1'b0}};
         formatter_sync_o <= 1'b0;
      end else begin
         group_sync_o <= grp_sync;
         formatter_sync_o <= next_fmt_sync;
      end
   end

   // ------------------------------------------------------------------
   // Read-back
   // ------------------------------------------------------------------
   reg [DATA_W-1:0] next_rdata;
   integer i;

   // Unmapped offsets read as zero
   always @* begin
      next_rdata = {DATA_W{1'b0}};
      case (reg_addr_i)
         `SSR_OFS_RSVD_A: begin
            next_rdata = rsvd_a;
         end
         `SSR_OFS_RSVD_B: begin
            next_rdata = rsvd_b;
         end
         `SSR_OFS_CORR_SEL: begin
            next_rdata = corr_sel;
         end
         `SSR_OFS_MIXOSC_SEL: begin
            next_rdata = mixosc_sel;
         end
         default: begin
            for (i = 0; i < `SSR_NUM_GROUPS; i = i + 1) begin
               if (reg_addr_i == `SSR_OFS_SHADOW_BASE + i) begin
                  next_rdata = grp_shadow[i];
               end
               if (reg_addr_i == `SSR_OFS_ACTIVE_BASE + i) begin
                  next_rdata = grp_active[i];
               end
            end
         end
      endcase
   end

   // Data valid only in the cycle after the read strobe
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= {DATA_W{1'b0}};
      end else if (reg_rd_i) begin
         reg_rdata_o <= next_rdata;
      end else begin
         reg_rdata_o <= {DATA_W{1'b0}};
      end
   end

endmodule

// ---- dv/ssr_sync_regs_assertions.sv ----
// Checker for the sync source select register bank.
// Assumes it is bound to ssr_sync_regs and sees only its ports.
`timescale 1ns/1ps
`include "ssr_defines.vh"
module ssr_sync_regs_assertions #(
   parameter ADDR_W = 8,
   parameter DATA_W = 16
) (
   // Clock, reset, register port
   input wire sys_clk_i,
   input wire sys_rst_i,
   input wire [ADDR_W-1:0] reg_addr_i,
   input wire [DATA_W-1:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [DATA_W-1:0] reg_rdata_o,
   // Sync sources and results
   input wire sync_pin_i,
   input wire output_strobe_pin_i,
   input wire frame_strobe_i,
   input wire [DATA_W-1:0] offset_active_o,
   input wire [`SSR_NUM_GROUPS-1:0] group_sync_o,
   input wire formatter_sync_o
);
   // -------------------------------------------------------------------
   // Mirror of both select registers, so enables are known here
   // -------------------------------------------------------------------
   reg [15:0] sel_c;
   reg [15:0] sel_m;
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         sel_c <= 16'h1111;
         sel_m <= 16'h1140;
      end else if (reg_wr_i && reg_addr_i == 8'h1E) begin
         sel_c <= reg_wdata_i;
      end else if (reg_wr_i && reg_addr_i == 8'h1F) begin
         sel_m <= reg_wdata_i;
      end
   end
   // Software, pin and strobe sources are shared by every group
   wire [2:0] ext = {sel_m[1], sync_pin_i, output_strobe_pin_i};
   wire [15:0] sel_rd = reg_addr_i[0] ? sel_m : sel_c;
   wire [3:0] grp;
   assign grp[0] = |(sel_c[15:12] & {ext, reg_wr_i && reg_addr_i == 8'h10});
   assign grp[1] = |(sel_c[7:4] & {ext, reg_wr_i && reg_addr_i == 8'h11});
   assign grp[2] = |(sel_m[15:12] & {ext, reg_wr_i && reg_addr_i == 8'h12});
   assign grp[3] = |(sel_m[7:4] & {ext, frame_strobe_i});
   wire fmt = (sel_m[3:2] == 2'h0) ? frame_strobe_i :
      (sel_m[3:2] == 2'h1) ? sync_pin_i : 1'b0;

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   // -------------------------------------------------------------------
   // Properties
   // -------------------------------------------------------------------
   chk_rd_idle_zero: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
      else $error("read data not zero outside a read");
   chk_sel_readback: assert property (
      reg_rd_i && reg_addr_i[7:1] == 7'h0F |=> reg_rdata_o == $past(sel_rd))
      else $error("select register read back wrong");
   chk_offset_sync: assert property (grp[0] |=> group_sync_o[0])
      else $error("offset group missed a sync");
   chk_corr_sync: assert property (group_sync_o[1] == $past(grp[1]))
      else $error("correction group sync wrong");
   chk_mixer_sync: assert property (!grp[2] |=> !group_sync_o[2])
      else $error("mixer group synced without source");
   chk_osc_sync: assert property (group_sync_o[3] == $past(grp[3]))
      else $error("oscillator group sync wrong");
   chk_active_hold: assert property (
      !group_sync_o[0] |-> offset_active_o == $past(offset_active_o))
      else $error("offset active changed without sync");
   chk_auto_data: assert property (
      reg_wr_i && reg_addr_i == 8'h10 && sel_c[12]
      |=> offset_active_o == $past(reg_wdata_i))
      else $error("auto sync did not load written data");
   chk_fmt_select: assert property (formatter_sync_o == $past(fmt))
      else $error("formatter sync source wrong");
endmodule

bind ssr_sync_regs ssr_sync_regs_assertions #(
   .ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_chk (
   .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .sync_pin_i(sync_pin_i),
   .output_strobe_pin_i(output_strobe_pin_i),
   .frame_strobe_i(frame_strobe_i), .offset_active_o(offset_active_o),
   .group_sync_o(group_sync_o), .formatter_sync_o(formatter_sync_o));

// ---- dv/tb.sv ----
// Testbench for the sync source select register bank.
// Drives the register port and sync pins itself; no partner model.
`timescale 1ns/1ps
module tb;
   reg sys_clk_i = 1'b0;
   reg sys_rst_i = 1'b1;
   reg [7:0] reg_addr_i = 8'h00;
   reg [15:0] reg_wdata_i = 16'h0000;
   reg reg_wr_i = 1'b0;
   reg reg_rd_i = 1'b0;
   reg sync_pin_i = 1'b0;
   reg output_strobe_pin_i = 1'b0;
   reg frame_strobe_i = 1'b0;
   wire [15:0] reg_rdata_o, off_a, corr_a, mix_a, osc_a;
   wire [3:0] gs;
   wire fs;
   integer fails = 0;
   integer checks_done = 0;
   integer i;

   always #2.5 sys_clk_i = ~sys_clk_i;

   ssr_sync_regs i_ssr_sync_regs (.sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .sync_pin_i(sync_pin_i),
      .output_strobe_pin_i(output_strobe_pin_i),
      .frame_strobe_i(frame_strobe_i), .offset_active_o(off_a),
      .corr_active_o(corr_a), .mixer_active_o(mix_a),
      .osc_phase_active_o(osc_a), .group_sync_o(gs),
      .formatter_sync_o(fs));

   // -------------------------------------------------------------------
   // Access tasks; results are sampled 1 ns after the edge has landed
   // -------------------------------------------------------------------
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp) begin
            fails = fails + 1;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [15:0] d);
      begin
         @(posedge sys_clk_i);
         reg_wr_i <= 1'b1;
         reg_addr_i <= a;
         reg_wdata_i <= d;
         @(posedge sys_clk_i);
         reg_wr_i <= 1'b0;
         #1;
      end
   endtask
   task rd(input [7:0] a, input [15:0] exp);
      begin
         @(posedge sys_clk_i);
         reg_rd_i <= 1'b1;
         reg_addr_i <= a;
         @(posedge sys_clk_i);
         reg_rd_i <= 1'b0;
         #1 chk(reg_rdata_o, exp);
      end
   endtask
   // One-cycle pulse on {sync pin, strobe pin, frame strobe}
   task pulse(input [2:0] s);
      begin
         @(posedge sys_clk_i);
         {sync_pin_i, output_strobe_pin_i, frame_strobe_i} <= s;
         @(posedge sys_clk_i);
         {sync_pin_i, output_strobe_pin_i, frame_strobe_i} <= 3'b000;
         #1;
      end
   endtask
   task results;
      begin
         $display("checks_done=%0d fails=%0d", checks_done, fails);
         if (fails == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask

   // -------------------------------------------------------------------
   // Test sequence
   // -------------------------------------------------------------------
   initial begin
      repeat (3) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      rd(8'h1C, 16'h0000);
      rd(8'h1D, 16'h0000);
      rd(8'h1E, 16'h1111);
      rd(8'h1F, 16'h1140);
      rd(8'h40, 16'h0000);
      wr(8'h10, 16'hA5A5);
      chk(off_a, 16'hA5A5);
      chk({12'h000, gs}, 16'h0001);
      wr(8'h11, 16'h1234);
      chk(corr_a, 16'h1234);
      wr(8'h12, 16'h7E7E);
      chk(mix_a, 16'h7E7E);
      wr(8'h13, 16'h0F0F);
      chk(osc_a, 16'h0000);
      pulse(3'b100);
      chk(osc_a, 16'h0F0F);
      // Offset group with every source off; reserved bits kept at default
      wr(8'h1E, 16'h0111);
      wr(8'h10, 16'h5A5A);
      chk(off_a, 16'hA5A5);
      rd(8'h10, 16'h5A5A);
      rd(8'h14, 16'hA5A5);
      pulse(3'b111);
      chk(off_a, 16'hA5A5);
      wr(8'h1E, 16'h4111);
      pulse(3'b010);
      chk(off_a, 16'hA5A5);
      pulse(3'b100);
      chk(off_a, 16'h5A5A);
      wr(8'h10, 16'h6B6B);
      wr(8'h1E, 16'h6111);
      pulse(3'b010);
      chk(off_a, 16'h6B6B);
      // Mixer on software sync only: set then clear the sync bit
      wr(8'h1F, 16'h8140);
      wr(8'h12, 16'hC3C3);
      chk(mix_a, 16'h7E7E);
      wr(8'h1F, 16'h8142);
      wr(8'h1F, 16'h8140);
      chk(mix_a, 16'hC3C3);
      for (i = 0; i < 4; i = i + 1) begin
         wr(8'h1F, {12'h114, i[1:0], 2'b00});
         pulse(3'b001);
         chk({15'h0000, fs}, {15'h0000, i == 0});
         pulse(3'b100);
         chk({15'h0000, fs}, {15'h0000, i == 1});
      end
      results;
   end

   // Watchdog: the sequence needs well under 1000 cycles
   initial begin
      #20000;
      fails = fails + 1;
      results;
   end
endmodule
